/* File: core/sfac_core.v */
`timescale 1ns/10ps
`default_nettype none
`include "sfac_defines.vh"

module sfac_core #(
   parameter [19:0] PROG_CYC = `SFAC_PROG_CYC,
   // Arbitrary identifier value.
   parameter [7:0] DEV_ID = 8'h3c
) (
   // Clock, reset, enable
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   // Serial pins
   input wire i_cs_n,
   input wire i_sclk,
   input wire i_si,
   output wire o_so,
   output wire o_so_oe,
   // Array engine side
   input wire i_ext_op_start,
   input wire i_ext_op_erase,
   input wire i_ext_op_done,
   output wire o_array_hold,
   // Configuration
   input wire [2:0] i_secreg_lock_bits,
   // Status
   output wire o_write_enable_latch,
   output wire o_write_in_progress,
   output wire [1:0] o_suspend_flags,
   output wire o_deep_sleep,
   output wire o_reset_busy,
   output wire o_volatile_clear,
   output wire o_cmd_blocked
);

   localparam [19:0] SUS_CYC = `SFAC_SUS_CYC;
   localparam [19:0] DP_CYC = `SFAC_DP_CYC;
   localparam [19:0] WAKE_CYC = `SFAC_WAKE_CYC;
   localparam [19:0] WAKE_ID_CYC = `SFAC_WAKE_ID_CYC;
   localparam [19:0] RST_CYC = `SFAC_RST_CYC;

   //-------------------------------------------------------------------
   // Functions
   //-------------------------------------------------------------------
   function secreg_ok;
      input [23:0] a;
      begin
         secreg_ok = (a[23:16] == 8'h00) && (a[15:12] != 4'h0) &&
                     (a[15:12] <= 4'h3) && (a[11:10] == 2'h0);
      end
   endfunction

   function [11:0] secreg_idx;
      input [3:0] sel;
      input [9:0] off;
      begin
         secreg_idx = {sel[1:0] - 2'h1, off};
      end
   endfunction

   //-------------------------------------------------------------------
   // Pin synchronisation
   //-------------------------------------------------------------------
   wire sel;
   wire cs_fall;
   wire cs_rise;
   wire sclk_rise;
   wire sclk_fall;
   wire si;

   sfac_pin_sync u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_cs_n(i_cs_n),
      .i_sclk(i_sclk),
      .i_si(i_si),
      .o_sel(sel),
      .o_cs_fall(cs_fall),
      .o_cs_rise(cs_rise),
      .o_sclk_rise(sclk_rise),
      .o_sclk_fall(sclk_fall),
      .o_si(si)
   );

   //-------------------------------------------------------------------
   // State
   //-------------------------------------------------------------------
   reg [7:0] mem [0:`SFAC_SR_BYTES-1];
   reg [7:0] pbuf [0:255];
   reg [255:0] pval_r;
   reg [7:0] pnext_r;
   reg [3:0] pbase_r;
   reg [8:0] pj_r;
   reg [7:0] op_r;
   reg [6:0] sh_r;
   reg [2:0] bit_r;
   reg [2:0] byte_r;
   reg got_op_r;
   reg frm_ok_r;
   reg [23:0] addr_r;
   reg wel_r;
   reg prog_busy_r;
   reg [19:0] prog_cnt_r;
   reg ext_busy_r;
   reg ext_erase_r;
   reg ext_wip_r;
   reg [1:0] sus_r;
   reg [19:0] sus_cnt_r;
   reg rst_en_r;
   reg [19:0] rst_cnt_r;
   reg sleep_r;
   reg [19:0] dp_cnt_r;
   reg [19:0] wake_cnt_r;
   reg [7:0] tx_r;
   reg [2:0] tcnt_r;
   reg tx_on_r;
   reg id_mode_r;
   reg rd_ok_r;
   reg [9:0] rd_off_r;
   reg so_r;
   reg vclr_r;
   reg blk_r;
   integer k;

   wire write_in_progress = prog_busy_r | ext_wip_r;
   wire rst_busy = (rst_cnt_r != 20'h0);
   wire wake_busy = (wake_cnt_r != 20'h0);
   wire rx_done = sclk_rise & sel & (bit_r == 3'h7);
   wire [7:0] rx_byte = {sh_r, si};
   wire [23:0] addr_nxt = {addr_r[15:0], rx_byte};
   wire sleep_ok = ~sleep_r | (op_r == `SFAC_OP_WAKE) |
                   (op_r == `SFAC_OP_RST_EN) | (op_r == `SFAC_OP_RST);
   wire live = frm_ok_r & got_op_r & sleep_ok;
   wire whole = (bit_r == 3'h0);
   wire [7:0] rd_byte = rd_ok_r ?
                        mem[secreg_idx(addr_r[15:12], rd_off_r)] :
                        `SFAC_SR_ERASED;
   wire prog_ok = (op_r == `SFAC_OP_SR_PROG) && (byte_r >= 3'h5) &&
                  whole && wel_r && !write_in_progress && secreg_ok(addr_r) &&
                  !i_secreg_lock_bits[addr_r[13:12] - 2'h1] &&
                  (sus_r != `SFAC_SUS_PROG);

   //-------------------------------------------------------------------
   // Opcodes refused while suspended
   //-------------------------------------------------------------------
   reg erase_set;
   reg prog_set;
   always @* begin
      erase_set = 1'b0;
      prog_set = 1'b0;
      case (rx_byte)
         `SFAC_OP_WRSR1, `SFAC_OP_WRSR2, `SFAC_OP_WRSR3,
         `SFAC_OP_SR_ERASE, `SFAC_OP_SE, `SFAC_OP_BE32, `SFAC_OP_BE64,
         `SFAC_OP_CE1, `SFAC_OP_CE2: begin
            erase_set = 1'b1;
            prog_set = 1'b1;
         end
         `SFAC_OP_SR_PROG, `SFAC_OP_PP, `SFAC_OP_QPP: begin
            prog_set = 1'b1;
         end
         default: begin
            erase_set = 1'b0;
         end
      endcase
   end

   //-------------------------------------------------------------------
   // Non-volatile storage and page buffer
   //-------------------------------------------------------------------
   // Erased fill stands for the factory state of the registers.
   initial begin
      for (k = 0; k < `SFAC_SR_BYTES; k = k + 1) begin
         mem[k] = `SFAC_SR_ERASED;
      end
   end

   // Programming only clears bits, as a flash cell would.
   always @(posedge i_clk) begin
      if (i_ce && prog_busy_r && !pj_r[8] && pval_r[pj_r[7:0]]) begin
         mem[{pbase_r, pj_r[7:0]}] <=
            mem[{pbase_r, pj_r[7:0]}] & pbuf[pj_r[7:0]];
      end
   end

   // The buffer is frozen while a program runs so it cannot be torn.
   always @(posedge i_clk) begin
      if (i_ce && rx_done && live && !prog_busy_r &&
          (op_r == `SFAC_OP_SR_PROG) && (byte_r >= 3'h4)) begin
         pbuf[pnext_r] <= rx_byte;
      end
   end

   //-------------------------------------------------------------------
   // Control
   //-------------------------------------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         pval_r <= 256'h0;
         pnext_r <= 8'h00;
         pbase_r <= 4'h0;
         pj_r <= 9'h000;
         op_r <= 8'h00;
         sh_r <= 7'h00;
         bit_r <= 3'h0;
         byte_r <= 3'h0;
         got_op_r <= 1'b0;
         frm_ok_r <= 1'b0;
         addr_r <= 24'h000000;
         wel_r <= 1'b0;
         prog_busy_r <= 1'b0;
         prog_cnt_r <= 20'h0;
         ext_busy_r <= 1'b0;
         ext_erase_r <= 1'b0;
         ext_wip_r <= 1'b0;
         sus_r <= 2'h0;
         sus_cnt_r <= 20'h0;
         rst_en_r <= 1'b0;
         rst_cnt_r <= 20'h0;
         sleep_r <= 1'b0;
         dp_cnt_r <= 20'h0;
         wake_cnt_r <= 20'h0;
         tx_r <= 8'h00;
         tcnt_r <= 3'h0;
         tx_on_r <= 1'b0;
         id_mode_r <= 1'b0;
         rd_ok_r <= 1'b0;
         rd_off_r <= 10'h000;
         so_r <= 1'b0;
         vclr_r <= 1'b0;
         blk_r <= 1'b0;
      end else if (i_ce) begin
         vclr_r <= 1'b0;
         blk_r <= 1'b0;

         // Frame framing.
         if (cs_fall) begin
            bit_r <= 3'h0;
            byte_r <= 3'h0;
            got_op_r <= 1'b0;
            frm_ok_r <= ~rst_busy & ~wake_busy;
            // A status poll during a program must not drop queued bytes.
            if (!prog_busy_r) begin
               pval_r <= 256'h0;
            end
            tx_on_r <= 1'b0;
         end else if (sclk_rise && sel) begin
            sh_r <= rx_byte[6:0];
            bit_r <= bit_r + 3'h1;
         end
         if (rx_done) begin
            if (byte_r != 3'h7) begin
               byte_r <= byte_r + 3'h1;
            end
            if (byte_r == 3'h0) begin
               op_r <= rx_byte;
               got_op_r <= 1'b1;
               blk_r <= frm_ok_r & ((sus_r[0] & prog_set) |
                        (sus_r[1] & erase_set));
            end else if (byte_r <= 3'h3) begin
               addr_r <= addr_nxt;
               rd_off_r <= addr_nxt[9:0];
               pnext_r <= addr_nxt[7:0];
               rd_ok_r <= secreg_ok(addr_nxt);
            end
            if (live && (op_r == `SFAC_OP_SR_PROG) && (byte_r >= 3'h4) &&
                !prog_busy_r) begin
               pval_r[pnext_r] <= 1'b1;
               pnext_r <= pnext_r + 8'h01;
            end
            if (live && (op_r == `SFAC_OP_SR_READ) &&
                (byte_r == 3'h4)) begin
               tx_r <= rd_byte;
               rd_off_r <= rd_off_r + 10'h001;
               tx_on_r <= 1'b1;
               id_mode_r <= 1'b0;
               tcnt_r <= 3'h0;
            end
            if (live && (op_r == `SFAC_OP_WAKE) && (byte_r == 3'h3) &&
                !write_in_progress) begin
               tx_r <= DEV_ID;
               tx_on_r <= 1'b1;
               id_mode_r <= 1'b1;
               tcnt_r <= 3'h0;
            end
         end

         // Data out on falling serial clock.
         if (sclk_fall && sel && tx_on_r) begin
            so_r <= tx_r[7];
            tcnt_r <= tcnt_r + 3'h1;
            if (tcnt_r == 3'h7) begin
               tx_r <= id_mode_r ? DEV_ID : rd_byte;
               rd_off_r <= rd_off_r + 10'h001;
            end else begin
               tx_r <= {tx_r[6:0], 1'b0};
            end
         end

         // Array engine bookkeeping.
         if (i_ext_op_start && !write_in_progress && !ext_busy_r) begin
            ext_busy_r <= 1'b1;
            ext_wip_r <= 1'b1;
            ext_erase_r <= i_ext_op_erase;
         end
         if (i_ext_op_done && ext_busy_r) begin
            ext_busy_r <= 1'b0;
            ext_wip_r <= 1'b0;
         end
         if (sus_cnt_r != 20'h0) begin
            sus_cnt_r <= sus_cnt_r - 20'h1;
            if (sus_cnt_r == 20'h1) begin
               ext_wip_r <= 1'b0;
            end
         end

         // Self-timed program cycle.
         if (prog_busy_r) begin
            if (!pj_r[8]) begin
               pj_r <= pj_r + 9'h001;
            end
            prog_cnt_r <= prog_cnt_r - 20'h1;
            if (prog_cnt_r == 20'h1) begin
               prog_busy_r <= 1'b0;
            end
         end

         // Timers for sleep entry, wake and reset recovery.
         if (dp_cnt_r != 20'h0) begin
            dp_cnt_r <= dp_cnt_r - 20'h1;
            if (dp_cnt_r == 20'h1) begin
               sleep_r <= 1'b1;
            end
         end
         if (wake_busy) begin
            wake_cnt_r <= wake_cnt_r - 20'h1;
         end
         if (rst_busy) begin
            rst_cnt_r <= rst_cnt_r - 20'h1;
         end

         // Commands that act when chip select rises.
         if (cs_rise && live) begin
            tx_on_r <= 1'b0;
            rst_en_r <= (op_r == `SFAC_OP_RST_EN) && whole;
            case (op_r)
               `SFAC_OP_WRITE_ENABLE_CMD: begin
                  if (!write_in_progress) begin
                     wel_r <= 1'b1;
                  end
               end
               `SFAC_OP_SR_PROG: begin
                  if (prog_ok) begin
                     prog_busy_r <= 1'b1;
                     prog_cnt_r <= PROG_CYC;
                     wel_r <= 1'b0;
                     pj_r <= 9'h000;
                     pbase_r <= {addr_r[13:12] - 2'h1, addr_r[9:8]};
                  end
               end
               `SFAC_OP_PAUSE: begin
                  if (ext_busy_r && ext_wip_r && (sus_r == 2'h0) &&
                      (sus_cnt_r == 20'h0)) begin
                     sus_r <= ext_erase_r ? `SFAC_SUS_ERASE :
                              `SFAC_SUS_PROG;
                     sus_cnt_r <= SUS_CYC;
                  end
               end
               `SFAC_OP_CONT: begin
                  if ((sus_r != 2'h0) && !write_in_progress && (sus_cnt_r == 20'h0)) begin
                     sus_r <= 2'h0;
                     ext_wip_r <= 1'b1;
                  end
               end
               `SFAC_OP_SLEEP: begin
                  if ((byte_r == 3'h1) && whole && !write_in_progress) begin
                     dp_cnt_r <= DP_CYC;
                  end
               end
               `SFAC_OP_WAKE: begin
                  if (!write_in_progress && (sleep_r || dp_cnt_r != 20'h0)) begin
                     sleep_r <= 1'b0;
                     dp_cnt_r <= 20'h0;
                     wake_cnt_r <= (byte_r >= 3'h4) ? WAKE_ID_CYC :
                                   WAKE_CYC;
                  end
               end
               default: begin
                  // Reset enable is already decided above for every live frame.
               end
            endcase
            // Reset wins over everything decided above in this frame.
            if ((op_r == `SFAC_OP_RST) && whole && rst_en_r) begin
               rst_en_r <= 1'b0;
               rst_cnt_r <= RST_CYC;
               wel_r <= 1'b0;
               prog_busy_r <= 1'b0;
               ext_busy_r <= 1'b0;
               ext_wip_r <= 1'b0;
               sus_r <= 2'h0;
               sus_cnt_r <= 20'h0;
               sleep_r <= 1'b0;
               dp_cnt_r <= 20'h0;
               wake_cnt_r <= 20'h0;
               vclr_r <= 1'b1;
            end
         end else if (cs_rise) begin
            tx_on_r <= 1'b0;
         end
      end
   end

   //-------------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------------
   assign o_so = so_r;
   assign o_so_oe = sel & tx_on_r;
   assign o_array_hold = (sus_r != 2'h0);
   assign o_write_enable_latch = wel_r;
   assign o_write_in_progress = write_in_progress;
   assign o_suspend_flags = sus_r;
   assign o_deep_sleep = sleep_r;
   assign o_reset_busy = rst_busy;
   assign o_volatile_clear = vclr_r;
   assign o_cmd_blocked = blk_r;

endmodule // sfac_core

`default_nettype wire

/* File: core/sfac_defines.vh */
//----------------------------------------------------------------------
// Contract
//----------------------------------------------------------------------
// Contract
// - Write enable latch set, then opcode, three address bytes, data.
// - Chip select rise starts timed program; busy held, latch cleared.
// - A locked security register refuses every program request.
// - Address: top byte zero, bits 15-12 register 1-3, offset 9-0.
// - Read: opcode, three address bytes, dummy, then data on falls.
// - Read offset increments per byte, wraps inside the register.
// - Software reset needs reset-enable frame then reset frame.
// - Reset aborts operations and clears all volatile state.
// - No command accepted during reset recovery time.
// - Suspend accepted only during running program or erase.
// - Suspend sets flag now, clears busy within suspend latency.
// - Program suspend blocks status, secreg, erase, page program.
// - Erase suspend blocks status writes, secreg erase, erases.
// - Resume accepted only with a suspend flag set, not busy.
// - Resume clears flag now, sets busy within 200 ns.
// - Deep sleep ignores all but wake/identify and reset pair.
// - Sleep entry only when frame is exactly eight bits.
// - Sleep entry rejected while any cycle is busy.
// - After wake, device waits wake time before new commands.
// - Identify: opcode, three dummies, identifier repeated MSB first.
// - Wake/identify ignored while busy.
// - Three security registers of 1024 bytes each.
`ifndef SFAC_DEFINES_VH
`define SFAC_DEFINES_VH

//----------------------------------------------------------------------
// Opcodes
//----------------------------------------------------------------------
`define SFAC_OP_WRITE_ENABLE_CMD 8'h06
`define SFAC_OP_SR_PROG 8'h42
`define SFAC_OP_SR_READ 8'h48
`define SFAC_OP_SR_ERASE 8'h44
`define SFAC_OP_RST_EN 8'h66
`define SFAC_OP_RST 8'h99
`define SFAC_OP_PAUSE 8'h75
`define SFAC_OP_CONT 8'h7a
`define SFAC_OP_SLEEP 8'hb9
`define SFAC_OP_WAKE 8'hab
`define SFAC_OP_WRSR1 8'h01
`define SFAC_OP_WRSR2 8'h31
`define SFAC_OP_WRSR3 8'h11
`define SFAC_OP_SE 8'h20
`define SFAC_OP_BE32 8'h52
`define SFAC_OP_BE64 8'hd8
`define SFAC_OP_CE1 8'hc7
`define SFAC_OP_CE2 8'h60
`define SFAC_OP_PP 8'h02
`define SFAC_OP_QPP 8'h32

//----------------------------------------------------------------------
// Security register layout
//----------------------------------------------------------------------
`define SFAC_SR_BYTES 3072
`define SFAC_SR_ERASED 8'hff
`define SFAC_SUS_PROG 2'b01
`define SFAC_SUS_ERASE 2'b10

//----------------------------------------------------------------------
// Timing
//----------------------------------------------------------------------
`define SFAC_CLK_NS 50
`define SFAC_PROG_TIME_NS 600000
`define SFAC_PROG_CYC ((`SFAC_PROG_TIME_NS+`SFAC_CLK_NS-1)/`SFAC_CLK_NS)
`define SFAC_SUS_TIME_NS 20000
`define SFAC_SUS_CYC (`SFAC_SUS_TIME_NS/`SFAC_CLK_NS)
`define SFAC_DP_TIME_NS 3000
`define SFAC_DP_CYC ((`SFAC_DP_TIME_NS+`SFAC_CLK_NS-1)/`SFAC_CLK_NS)
`define SFAC_WAKE_TIME_NS 20000
`define SFAC_WAKE_CYC ((`SFAC_WAKE_TIME_NS+`SFAC_CLK_NS-1)/`SFAC_CLK_NS)
`define SFAC_WAKE_ID_TIME_NS 20000
`define SFAC_WAKE_ID_CYC \
   ((`SFAC_WAKE_ID_TIME_NS+`SFAC_CLK_NS-1)/`SFAC_CLK_NS)
`define SFAC_RST_TIME_NS 30000
`define SFAC_RST_CYC ((`SFAC_RST_TIME_NS+`SFAC_CLK_NS-1)/`SFAC_CLK_NS)

`endif

/* File: core/sfac_pin_sync.v */
`timescale 1ns/10ps
`default_nettype none

module sfac_pin_sync (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   // Raw pins
   input wire i_cs_n,
   input wire i_sclk,
   input wire i_si,
   // Synchronised view
   output wire o_sel,
   output wire o_cs_fall,
   output wire o_cs_rise,
   output wire o_sclk_rise,
   output wire o_sclk_fall,
   output wire o_si
);

   //-------------------------------------------------------------------
   // Two-stage synchronisers, then edge detection on the second stage
   //-------------------------------------------------------------------
   reg [2:0] meta_r;
   reg [2:0] sync_r;
   reg [1:0] prev_r;

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_r <= 3'h4;
         sync_r <= 3'h4;
         prev_r <= 2'h2;
      end else if (i_ce) begin
         meta_r <= {i_cs_n, i_sclk, i_si};
         sync_r <= meta_r;
         prev_r <= sync_r[2:1];
      end
   end

   assign o_sel = ~sync_r[2];
   assign o_cs_fall = prev_r[1] & ~sync_r[2];
   assign o_cs_rise = ~prev_r[1] & sync_r[2];
   assign o_sclk_rise = ~prev_r[0] & sync_r[1];
   assign o_sclk_fall = prev_r[0] & ~sync_r[1];
   assign o_si = sync_r[0];

endmodule // sfac_pin_sync

`default_nettype wire

/* File: sim/sfac_core_chk.sv */
`timescale 1ns/10ps
`default_nettype none

module sfac_core_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Watched status
   input wire logic o_write_enable_latch,
   input wire logic o_write_in_progress,
   input wire logic [1:0] o_suspend_flags,
   input wire logic o_deep_sleep,
   input wire logic o_reset_busy,
   input wire logic o_volatile_clear,
   input wire logic o_cmd_blocked
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   //-------------------------------------------------------------------
   // Suspend and resume steps
   //-------------------------------------------------------------------
   sequence s_pause;
      $rose(|o_suspend_flags);
   endsequence
   sequence s_resume;
      $fell(|o_suspend_flags);
   endsequence

   a_pause_busy:
      assert property (s_pause |-> $past(o_write_in_progress))
      else $error("suspend taken while idle");
   a_pause_idle:
      assert property (s_pause |-> ##[1:402] !o_write_in_progress)
      else $error("busy did not drop after suspend");
   a_resume_busy:
      assert property (s_resume |->
         ##[0:4] (o_write_in_progress || o_reset_busy))
      else $error("busy not back after resume");
   a_one_kind:
      assert property (o_suspend_flags != 2'b11)
      else $error("both suspend kinds set");
   a_blk_only_sus:
      assert property (o_cmd_blocked |-> |o_suspend_flags)
      else $error("refusal without suspend");
   a_reset_clear:
      assert property (o_volatile_clear |-> ##[0:1] (o_reset_busy &&
         !o_write_enable_latch && !o_write_in_progress &&
         o_suspend_flags == 2'b00 && !o_deep_sleep))
      else $error("state left after reset");
   a_recover_quiet:
      assert property (o_reset_busy && $past(o_reset_busy) |->
         !$rose(o_write_enable_latch))
      else $error("command taken in recovery");
   a_sleep_quiet:
      assert property (o_deep_sleep && $past(o_deep_sleep) |->
         !$rose(o_write_enable_latch) && !$rose(|o_suspend_flags))
      else $error("command taken asleep");
   a_sleep_idle:
      assert property ($rose(o_deep_sleep) |-> !o_write_in_progress)
      else $error("sleep entered while busy");
   a_wel_done:
      assert property ($fell(o_write_in_progress) &&
         o_suspend_flags == 2'b00 |-> !o_write_enable_latch)
      else $error("latch still set after cycle");
endmodule // sfac_core_chk

`default_nettype wire

/* File: sim/sfac_host.sv */
`timescale 1ns/10ps
`default_nettype none

module sfac_host (
   // Clock
   input wire logic i_clk,
   // Serial pins
   input wire logic i_so,
   output var logic o_cs_n,
   output var logic o_sclk,
   output var logic o_si
);
   logic [7:0] rx;
   logic [7:0] got[$];

   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_si = 1'b0;
      rx = 8'h00;
   end

   // Four system clocks per half period; three is the shortest at which the answer is still read in time.
   task half;
      repeat (4) @(posedge i_clk);
      #1;
   endtask

   // MSB first, taken on the rising link edge; the answer is read at that
   // same edge, one system clock after the device moved it.
   task xb(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         o_si = b[i];
         half();
         o_sclk = 1'b1;
         rx = {rx[6:0], i_so};
         half();
         o_sclk = 1'b0;
      end
   endtask

   // Whole bytes only, link clock still between frames, data line not
   // held after deselect, then chip select kept high.
   task frm(input logic [7:0] q[$]);
      got = {};
      o_cs_n = 1'b0;
      foreach (q[i]) begin
         xb(q[i]);
         got.push_back(rx);
      end
      half();
      o_cs_n = 1'b1;
      o_si = ~o_si;
      half();
      half();
   endtask
endmodule // sfac_host

`default_nettype wire

/* File: sim/sfac_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module sfac_core_bench;
   localparam int PCYC = 300;
   // Arbitrary identifier value.
   localparam logic [7:0] ID = 8'h5a;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ext_op_start = 1'b0;
   logic i_ext_op_erase = 1'b0;
   logic i_ext_op_done = 1'b0;
   logic [2:0] i_secreg_lock_bits = 3'h0;
   wire cs_n, sclk, si, so, so_oe, hold, write_enable_latch, write_in_progress, sleep, rbusy, vclr, blk;
   wire [1:0] sus;
   // A released output must not look like held data to the host.
   wire so_pin = so_oe ? so : ~si;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_vclr = 0;
   int n_blk = 0;

   always #25 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      if (vclr === 1'b1)
         n_vclr++;
      if (blk === 1'b1)
         n_blk++;
   end

   sfac_core #(.PROG_CYC(20'd300), .DEV_ID(ID)) dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si), .o_so(so), .o_so_oe(so_oe),
      .i_ext_op_start(i_ext_op_start), .i_ext_op_erase(i_ext_op_erase),
      .i_ext_op_done(i_ext_op_done), .o_array_hold(hold),
      .i_secreg_lock_bits(i_secreg_lock_bits),
      .o_write_enable_latch(write_enable_latch), .o_write_in_progress(write_in_progress),
      .o_suspend_flags(sus), .o_deep_sleep(sleep), .o_reset_busy(rbusy),
      .o_volatile_clear(vclr), .o_cmd_blocked(blk));
   sfac_host h (.i_clk(i_clk), .i_so(so_pin), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_si(si));

   task tick;
      @(posedge i_clk);
      #1;
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task ck(input logic [7:0] g, input logic [7:0] e, input string m);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %0t %s: got %h want %h", $time, m, g, e);
      end
   endtask
   task wt(input int n);
      for (int k = 0; k < n && write_in_progress !== 1'b0; k++)
         tick();
      if (write_in_progress !== 1'b0) begin
         n_mismatch++;
         $display("ERROR %0t busy never ended", $time);
         close_out();
      end
   endtask
   task sp(input logic we, input logic [7:0] a1, a2, d0, d1);
      if (we)
         h.frm('{8'h06});
      h.frm('{8'h42, 8'h00, a1, a2, d0, d1});
   endtask
   task rd(input logic [7:0] a1, a2);
      h.frm('{8'h48, 8'h00, a1, a2, 8'h00,
         8'h00, 8'h00, 8'h00, 8'h00});
   endtask

   task t_ident;
      h.frm('{8'hab, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      ck(h.got[4], ID, "identifier");
      ck(h.got[5], ID, "identifier again");
      repeat (420) tick();
   endtask
   task t_prog;
      sp(1'b1, 8'h13, 8'hfe, 8'ha5, 8'h0f);
      ck(8'({write_in_progress, write_enable_latch}), 8'h02, "busy, latch cleared");
      wt(PCYC + 20);
      sp(1'b1, 8'h10, 8'h00, 8'h12, 8'h34);
      wt(PCYC + 20);
      rd(8'h13, 8'hfe);
      ck(h.got[5], 8'ha5, "first byte");
      ck(h.got[6], 8'h0f, "top offset");
      ck(h.got[7], 8'h12, "wrap to zero");
      ck(h.got[8], 8'h34, "after wrap");
   endtask
   task t_lock;
      sp(1'b0, 8'h30, 8'h00, 8'h00, 8'h00);
      ck(8'(write_in_progress), 8'h00, "no latch, no cycle");
      i_secreg_lock_bits = 3'h2;
      sp(1'b1, 8'h20, 8'h00, 8'h00, 8'h00);
      ck(8'(write_in_progress), 8'h00, "locked, no cycle");
      rd(8'h20, 8'h00);
      ck(h.got[5], 8'hff, "locked contents kept");
      rd(8'h30, 8'h00);
      ck(h.got[5], 8'hff, "unlatched contents kept");
   endtask
   task t_reset;
      ck(8'({write_in_progress, sus}), 8'h00, "idle before reset");
      h.frm('{8'h06});
      h.frm('{8'h99});
      ck(8'(write_enable_latch), 8'h01, "lone reset ignored");
      h.frm('{8'h66});
      h.frm('{8'h99});
      ck(8'({write_enable_latch, rbusy}), 8'h01, "reset taken");
      ck(8'(n_vclr), 8'h01, "volatile clear");
      h.frm('{8'h06});
      ck(8'(write_enable_latch), 8'h00, "ignored in recovery");
      repeat (620) tick();
      ck(8'(rbusy), 8'h00, "recovery over");
   endtask
   task t_sus;
      for (int k = 0; k < 2; k++) begin
         i_ext_op_erase = k[0];
         i_ext_op_start = 1'b1;
         tick();
         i_ext_op_start = 1'b0;
         h.frm('{8'hb9});
         repeat (70) tick();
         ck(8'({sleep, write_in_progress}), 8'h01, "sleep refused");
         h.frm('{8'hab});
         ck(8'(write_in_progress), 8'h01, "wake ignored");
         h.frm('{8'h75});
         ck(8'({hold, sus}), k ? 8'h06 : 8'h05, "paused");
         wt(420);
         h.frm('{8'h02, 8'h00, 8'h00, 8'h00});
         if (k)
            h.frm('{8'h20, 8'h00, 8'h00, 8'h00});
         ck(8'(n_blk), 8'(k + 1), "refusals");
         h.frm('{8'h7a});
         ck(8'({hold, sus, write_in_progress}), 8'h01, "resumed");
         h.frm('{8'h7a});
         ck(8'({sus, write_in_progress}), 8'h01, "resume ignored");
         i_ext_op_done = 1'b1;
         tick();
         i_ext_op_done = 1'b0;
         wt(10);
         h.frm('{8'h75});
         ck(8'(sus), 8'h00, "idle pause ignored");
      end
   endtask
   task t_sleep;
      h.frm('{8'hb9, 8'h00});
      repeat (70) tick();
      ck(8'(sleep), 8'h00, "long frame, no sleep");
      h.frm('{8'hb9});
      repeat (70) tick();
      ck(8'(sleep), 8'h01, "asleep");
      h.frm('{8'h06});
      ck(8'(write_enable_latch), 8'h00, "ignored asleep");
      h.frm('{8'hab});
      h.frm('{8'h06});
      ck(8'({sleep, write_enable_latch}), 8'h00, "woken, settling");
      repeat (420) tick();
      h.frm('{8'h06});
      ck(8'(write_enable_latch), 8'h01, "commands again");
   endtask

   initial begin
      repeat (6) tick();
      i_rst_n = 1'b1;
      tick();
      t_ident();
      t_prog();
      t_lock();
      t_reset();
      t_sus();
      t_sleep();
      close_out();
   end
endmodule // sfac_core_bench

bind sfac_core sfac_core_chk chk (
   .i_clk, .i_rst_n, .o_write_enable_latch, .o_write_in_progress,
   .o_suspend_flags, .o_deep_sleep, .o_reset_busy, .o_volatile_clear,
   .o_cmd_blocked);

`default_nettype wire
